//--- core/dsp_dp.sv
// Purpose: operand paths, multiply-accumulate and shifter of the core
// Assumes: sequencer supplies decoded selects each cycle
// Notes: alu itself lives outside; its operands leave here
//
// Summary of operation
// RULE_01: alu operands from fixed register sets
// RULE_02: sequencer never pairs divide step, y0
// RULE_03: accumulator is 40 bits, three words
// RULE_04: multiplier signed, unsigned, rounded options
// RULE_05: shifter operand from its allowed set
// RULE_06: hi/lo reference selects result word
// RULE_07: extended reference adds overflow bit
// RULE_08: immediate shifts may OR into result
// RULE_09: normalize, exponent derive, block adjust
// RULE_10: zero/sign condition codes decoded
// RULE_11: carry, overflow, sign, counter tests
// RULE_12: immediate shift count 8-bit signed
// RULE_13: saturate accumulator on mac overflow
// RULE_14: pin conditions only on jump, call
`timescale 1ns/1ns
`include "dsp_dp_map.svh"
module dsp_dp #(
	parameter int W = `WORD_W,
	parameter int AW = `ACC_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] alu_x_input_0_i,
	input wire logic [W-1:0] alu_x_input_1_i,
	input wire logic [W-1:0] alu_y_input_0_i,
	input wire logic [W-1:0] alu_y_input_1_i,
	input wire logic [W-1:0] alu_feedback_i,
	input wire logic [W-1:0] alu_result_i,
	input wire logic [W-1:0] shifter_input_i,
	input wire dsp_dp_pkg::alu_xsel_t alu_xsel_i,
	input wire dsp_dp_pkg::alu_ysel_t alu_ysel_i,
	input wire dsp_dp_pkg::mac_req_t mac_req_i,
	input wire dsp_dp_pkg::sh_req_t sh_req_i,
	input wire dsp_dp_pkg::cond_t cond_i,
	input wire dsp_dp_pkg::status_t status_i,
	output logic [W-1:0] alu_x_o,
	output logic [W-1:0] alu_y_o,
	output logic [AW-1:0] mac_result_o,
	output logic mac_overflow_flag_o,
	output logic [2*W-1:0] shifter_result_o,
	output logic [7:0] shift_exponent_o,
	output logic [7:0] block_exponent_register_o,
	output logic cond_pass_o
);
	logic [AW-1:0] acc;
	logic [AW-1:0] next_acc;
	logic mv;
	logic next_mv;
	logic [2*W-1:0] sr;
	logic [2*W-1:0] next_sr;
	logic [7:0] se;
	logic [7:0] next_se;
	logic [7:0] sb;
	logic [7:0] next_sb;
	logic [W-1:0] mac_result_low;
	logic [W-1:0] mac_result_mid;
	logic [7:0] mac_result_top;
	logic [W-1:0] shx;
	logic pass;
	logic [W:0] sx_ext;
	logic [W:0] sy_ext;
	logic signed [2*W+1:0] prod;
	logic [AW-1:0] prod_acc;
	logic [AW-1:0] sum;
	logic signed [7:0] cnt;
	logic [4*W-1:0] field;
	logic [4*W-1:0] shifted;
	logic [7:0] lead;
	logic xsign;

	// RULE_03: three views of the accumulator
	assign mac_result_low = acc[`MID_LSB-1:0];
	assign mac_result_mid = acc[`TOP_LSB-1:`MID_LSB];
	assign mac_result_top = acc[AW-1:`TOP_LSB];

	// RULE_01: x operand set
	always_comb begin
		unique case (alu_xsel_i)
			dsp_dp_pkg::ALU_X0: alu_x_o = alu_x_input_0_i;
			dsp_dp_pkg::ALU_X1: alu_x_o = alu_x_input_1_i;
			dsp_dp_pkg::ALU_XR: alu_x_o = alu_result_i;
			dsp_dp_pkg::ALU_XML: alu_x_o = mac_result_low;
			dsp_dp_pkg::ALU_XMM: alu_x_o = mac_result_mid;
			dsp_dp_pkg::ALU_XMT: alu_x_o = {{(W-8){mac_result_top[7]}},
				mac_result_top};
			dsp_dp_pkg::ALU_XSL: alu_x_o = sr[W-1:0];
			dsp_dp_pkg::ALU_XSH: alu_x_o = sr[2*W-1:W];
			default: alu_x_o = alu_x_input_0_i;
		endcase
	end

	// RULE_01: y operand set; RULE_02: y0 with divide step never issued
	always_comb begin
		unique case (alu_ysel_i)
			dsp_dp_pkg::ALU_Y0: alu_y_o = alu_y_input_0_i;
			dsp_dp_pkg::ALU_Y1: alu_y_o = alu_y_input_1_i;
			dsp_dp_pkg::ALU_YF: alu_y_o = alu_feedback_i;
			default: alu_y_o = alu_feedback_i;
		endcase
	end

	// RULE_05: shifter operand set
	always_comb begin
		unique case (sh_req_i.xsel)
			dsp_dp_pkg::SH_SI: shx = shifter_input_i;
			dsp_dp_pkg::SH_SL: shx = sr[W-1:0];
			dsp_dp_pkg::SH_SH: shx = sr[2*W-1:W];
			dsp_dp_pkg::SH_ML: shx = mac_result_low;
			dsp_dp_pkg::SH_MM: shx = mac_result_mid;
			dsp_dp_pkg::SH_MT: shx = {{(W-8){mac_result_top[7]}},
				mac_result_top};
			default: shx = shifter_input_i;
		endcase
	end

	// RULE_11: sign of the alu x operand
	assign xsign = alu_x_o[W-1];
	// RULE_14: pin tests are not decoded here
	dsp_cond_eval u_cond (
		.cond_i(cond_i),
		.st_i(status_i),
		.xop_sign_i(xsign),
		.pass_o(pass)
	);
	assign cond_pass_o = pass;

	// RULE_04: operand signedness and rounding
	always_comb begin
		sx_ext = {mac_req_i.x_signed & mac_req_i.x[W-1], mac_req_i.x};
		sy_ext = {mac_req_i.y_signed & mac_req_i.y[W-1], mac_req_i.y};
		prod = $signed(sx_ext) * $signed(sy_ext);
		prod_acc = AW'(prod);
		sum = acc + prod_acc;
		if (mac_req_i.round) begin
			prod_acc = prod_acc + AW'(1 << (`MID_LSB - 1));
			sum = sum + AW'(1 << (`MID_LSB - 1));
		end
	end

	always_comb begin
		next_acc = acc;
		next_mv = mv;
		if (pass) begin
			unique case (mac_req_i.op)
				dsp_dp_pkg::MAC_NONE: next_acc = acc;
				dsp_dp_pkg::MAC_MUL: next_acc = prod_acc;
				dsp_dp_pkg::MAC_ACC: next_acc = sum;
				// RULE_13: clamp to signed extreme
				dsp_dp_pkg::MAC_SAT: begin
					if (mv)
						next_acc = acc[AW-1] ? {1'b1, {(AW-1){1'b0}}}
							: {1'b0, {(AW-1){1'b1}}};
				end
			endcase
			// overflow means top bits disagree with bit 31
			if (mac_req_i.op != dsp_dp_pkg::MAC_NONE)
				next_mv = !(&next_acc[AW-1:`TOP_LSB-1] ||
					~|next_acc[AW-1:`TOP_LSB-1]);
		end
	end

	// RULE_12: 8-bit signed count from the instruction when imm_en, else from se
	assign cnt = sh_req_i.imm_en ? $signed(sh_req_i.imm) : $signed(se);

	// RULE_09: leading sign bits of the input word
	always_comb begin
		lead = 8'h00;
		for (int i = W - 2; i >= 0; i--) begin
			if (shx[i] != shx[W-1])
				break;
			lead = lead + 8'h01;
		end
	end

	always_comb begin
		next_sr = sr;
		next_se = se;
		next_sb = sb;
		field = '0;
		shifted = '0;
		// RULE_06: place the word at high or low half
		if (sh_req_i.refsel == dsp_dp_pkg::REF_LO)
			field = {{(2*W){sh_req_i.op == dsp_dp_pkg::SOP_ARITHMETIC_SHIFT &
				shx[W-1]}}, {W{sh_req_i.op == dsp_dp_pkg::SOP_ARITHMETIC_SHIFT &
				shx[W-1]}}, shx};
		else
			field = {{(2*W){sh_req_i.op == dsp_dp_pkg::SOP_ARITHMETIC_SHIFT &
				shx[W-1]}}, shx, {W{1'b0}}};
		if (cnt[7])
			shifted = (sh_req_i.op == dsp_dp_pkg::SOP_ARITHMETIC_SHIFT) ?
				(4*W)'($signed(field) >>> (-cnt)) : field >> (-cnt);
		else
			shifted = field << cnt;
		if (pass) begin
			unique case (sh_req_i.op)
				dsp_dp_pkg::SOP_NONE: next_sr = sr;
				// RULE_08: optional OR into result
				dsp_dp_pkg::SOP_ARITHMETIC_SHIFT, dsp_dp_pkg::SOP_LOGICAL_SHIFT,
				dsp_dp_pkg::SOP_LEADING_BIT_ALIGN_SHIFT:
					next_sr = (sh_req_i.or_mode ? sr : '0) |
						shifted[2*W-1:0];
				dsp_dp_pkg::SOP_EXP: begin
					// RULE_07: overflow bit as extension
					if (sh_req_i.refsel == dsp_dp_pkg::REF_HIX &&
						status_i.ovf)
						next_se = 8'h01;
					else if (sh_req_i.refsel == dsp_dp_pkg::REF_HIX)
						next_se = -lead;
					else
						next_se = -lead;
				end
				// RULE_09: block exponent keeps the largest
				dsp_dp_pkg::SOP_BLOCK_SCALE_ADJUST:
					if ($signed(-lead) > $signed(sb))
						next_sb = -lead;
				// codes above the last op are illegal
				default: next_sr = sr;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= `ACC_RESET;
			mv <= 1'b0;
			sr <= {`WORD_RESET, `WORD_RESET};
			se <= `EXP_RESET;
			sb <= `BLOCK_EXP_RESET;
		end else begin
			acc <= next_acc;
			mv <= next_mv;
			sr <= next_sr;
			se <= next_se;
			sb <= next_sb;
		end
	end

	assign mac_result_o = acc;
	assign mac_overflow_flag_o = mv;
	assign shifter_result_o = sr;
	assign shift_exponent_o = se;
	assign block_exponent_register_o = sb;
endmodule

//--- core/dsp_dp_map.svh
// Purpose: constants for the datapath of the fixed-point core
// Assumes: included by its bare name
// Notes: operand select codes are local choices
`ifndef DSP_DP_MAP_SVH
`define DSP_DP_MAP_SVH
`define WORD_W 16
`define ACC_W 40
`define MID_LSB 16
`define TOP_LSB 32
`define IMM_W 8
`define ACC_RESET 40'h00_0000_0000
`define WORD_RESET 16'h0000
`define EXP_RESET 8'h00
`define BLOCK_EXP_RESET 8'hF0
`endif

//--- core/dsp_dp_pkg.sv
// Purpose: types for the datapath of the fixed-point core
// Assumes: none
// Notes: codes are binary, listed in full
package dsp_dp_pkg;
	typedef enum logic [3:0] {
		ALU_X0 = 4'h0, ALU_X1 = 4'h1, ALU_XR = 4'h2, ALU_XML = 4'h3,
		ALU_XMM = 4'h4, ALU_XMT = 4'h5, ALU_XSL = 4'h6, ALU_XSH = 4'h7
	} alu_xsel_t;
	typedef enum logic [1:0] {
		ALU_Y0 = 2'h0, ALU_Y1 = 2'h1, ALU_YF = 2'h2
	} alu_ysel_t;
	typedef enum logic [2:0] {
		SH_SI = 3'h0, SH_SL = 3'h1, SH_SH = 3'h2, SH_ML = 3'h3,
		SH_MM = 3'h4, SH_MT = 3'h5
	} sh_xsel_t;
	typedef enum logic [2:0] {
		SOP_NONE = 3'h0, SOP_ARITHMETIC_SHIFT = 3'h1, SOP_LOGICAL_SHIFT = 3'h2,
		SOP_LEADING_BIT_ALIGN_SHIFT = 3'h3, SOP_EXP = 3'h4, SOP_BLOCK_SCALE_ADJUST = 3'h5
	} sh_op_t;
	typedef enum logic [1:0] {
		REF_HI = 2'h0, REF_LO = 2'h1, REF_HIX = 2'h2
	} sh_ref_t;
	typedef enum logic [1:0] {
		MAC_NONE = 2'h0, MAC_MUL = 2'h1, MAC_ACC = 2'h2, MAC_SAT = 2'h3
	} mac_op_t;
	typedef enum logic [4:0] {
		C_EQ = 5'h00, C_NE = 5'h01, C_LT = 5'h02, C_GE = 5'h03,
		C_LE = 5'h04, C_GT = 5'h05, C_AC = 5'h06, C_NAC = 5'h07,
		C_AV = 5'h08, C_NAV = 5'h09, C_MV = 5'h0A, C_NMV = 5'h0B,
		C_NEG = 5'h0C, C_POS = 5'h0D, C_NCE = 5'h0E, C_TRUE = 5'h0F
	} cond_t;
	typedef struct packed {
		mac_op_t op;
		logic x_signed;
		logic y_signed;
		logic round;
		logic [15:0] x;
		logic [15:0] y;
	} mac_req_t;
	typedef struct packed {
		sh_op_t op;
		sh_ref_t refsel;
		logic or_mode;
		logic imm_en;
		logic [7:0] imm;
		sh_xsel_t xsel;
	} sh_req_t;
	typedef struct packed {
		logic zero;
		logic sign;
		logic carry;
		logic ovf;
		logic mac_ovf;
		logic ce;
	} status_t;
endpackage

//--- core/dsp_cond_eval.sv
// Purpose: evaluates a condition code against core status
// Assumes: status is the latest result's
// Notes: pure combinational
`timescale 1ns/1ns
module dsp_cond_eval (
	input wire dsp_dp_pkg::cond_t cond_i,
	input wire dsp_dp_pkg::status_t st_i,
	input wire logic xop_sign_i,
	output logic pass_o
);
	always_comb begin
		unique case (cond_i)
			// RULE_10: zero and sign codes
			dsp_dp_pkg::C_EQ: pass_o = st_i.zero;
			dsp_dp_pkg::C_NE: pass_o = !st_i.zero;
			dsp_dp_pkg::C_LT: pass_o = st_i.sign;
			dsp_dp_pkg::C_GE: pass_o = !st_i.sign;
			dsp_dp_pkg::C_LE: pass_o = st_i.sign | st_i.zero;
			dsp_dp_pkg::C_GT: pass_o = !(st_i.sign | st_i.zero);
			// RULE_11: flag and sign tests
			dsp_dp_pkg::C_AC: pass_o = st_i.carry;
			dsp_dp_pkg::C_NAC: pass_o = !st_i.carry;
			dsp_dp_pkg::C_AV: pass_o = st_i.ovf;
			dsp_dp_pkg::C_NAV: pass_o = !st_i.ovf;
			dsp_dp_pkg::C_MV: pass_o = st_i.mac_ovf;
			dsp_dp_pkg::C_NMV: pass_o = !st_i.mac_ovf;
			dsp_dp_pkg::C_NEG: pass_o = xop_sign_i;
			dsp_dp_pkg::C_POS: pass_o = !xop_sign_i;
			dsp_dp_pkg::C_NCE: pass_o = !st_i.ce;
			dsp_dp_pkg::C_TRUE: pass_o = 1'b1;
			default: pass_o = 1'b0;
		endcase
	end
endmodule

//--- bench/dsp_dp_chk.sv
// Purpose: port checks on the datapath
// Assumes: bound to dsp_dp, one clock
// Notes: mux checks are same-cycle
`timescale 1ns/1ns
module dsp_dp_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] alu_x_input_0_i,
	input wire dsp_dp_pkg::alu_xsel_t alu_xsel_i,
	input wire dsp_dp_pkg::mac_req_t mac_req_i,
	input wire dsp_dp_pkg::cond_t cond_i,
	input wire dsp_dp_pkg::status_t status_i,
	input wire logic [15:0] alu_x_o,
	input wire logic [39:0] mac_result_o,
	input wire logic mac_overflow_flag_o,
	input wire logic [31:0] shifter_result_o,
	input wire logic cond_pass_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	rst_clear_a:
	assert property ($fell(rst_i) |-> mac_result_o == '0 &&
		shifter_result_o == '0) else $error("state not cleared");
	x0_route_a:
	assert property (alu_xsel_i == dsp_dp_pkg::ALU_X0 |->
		alu_x_o == alu_x_input_0_i) else $error("x0 route wrong");
	mid_route_a:
	assert property (alu_xsel_i == dsp_dp_pkg::ALU_XMM |->
		alu_x_o == mac_result_o[31:16]) else $error("mid word wrong");
	mul_plain_a:
	assert property (cond_pass_o && mac_req_i.op == dsp_dp_pkg::MAC_MUL &&
		mac_req_i[34:32] == 3'h0 |=> mac_result_o ==
		40'($past(mac_req_i.x)) * 40'($past(mac_req_i.y)))
		else $error("unsigned product wrong");
	refused_op_a:
	assert property (!cond_pass_o |=> $stable(mac_result_o) &&
		$stable(shifter_result_o)) else $error("refused op changed state");
	sat_clamp_a:
	assert property (cond_pass_o && mac_req_i.op == dsp_dp_pkg::MAC_SAT &&
		mac_overflow_flag_o |=> mac_result_o inside
		{40'h7F_FFFF_FFFF, 40'h80_0000_0000}) else $error("no clamp");
	eq_code_a:
	assert property (cond_i == dsp_dp_pkg::C_EQ |->
		cond_pass_o == status_i.zero) else $error("equal test wrong");
	nav_code_a:
	assert property (cond_i == dsp_dp_pkg::C_NAV |->
		cond_pass_o == !status_i.ovf) else $error("not-ovf test wrong");
	cover property (cond_pass_o && mac_req_i.op == dsp_dp_pkg::MAC_SAT);
	cover property (!cond_pass_o && mac_req_i.op == dsp_dp_pkg::MAC_MUL);
	cover property (mac_overflow_flag_o);
endmodule
bind dsp_dp dsp_dp_chk dsp_dp_chk_i (.*);

//--- bench/dsp_seq_model.sv
// Purpose: sequencer side feeding the datapath
// Assumes: register contents fixed for the run
// Notes: behavioural, no state
`timescale 1ns/1ns
module dsp_seq_model (
	input wire logic divide_sign_step_i,
	input wire dsp_dp_pkg::alu_ysel_t ysel_i,
	input wire dsp_dp_pkg::cond_t cond_i,
	output dsp_dp_pkg::alu_ysel_t ysel_o,
	output dsp_dp_pkg::cond_t cond_o,
	output logic [5:0][15:0] regs_o
);
	assign ysel_o = (divide_sign_step_i && ysel_i == dsp_dp_pkg::ALU_Y0) ?
		dsp_dp_pkg::ALU_Y1 : ysel_i;
	assign cond_o = cond_i;
	// distinct patterns so a wrong route shows
	assign regs_o = {16'h0F0F, 16'hDEF0, 16'h9ABC, 16'h5678, 16'h1234,
		16'h8001};
endmodule

//--- bench/dsp_dp_tb_top.sv
// Purpose: self-checking bench for the datapath
// Assumes: results show one cycle after the op edge
// Notes: tests run in order, state carries over
`timescale 1ns/1ns
module dsp_dp_tb_top;
	logic clk_i, rst_i, divide_sign_step, mv, pass;
	logic [15:0] sin, ax, ay;
	logic [5:0][15:0] regs;
	logic [39:0] mr;
	logic [31:0] sr;
	logic [7:0] se, sb;
	dsp_dp_pkg::alu_xsel_t xsel;
	dsp_dp_pkg::alu_ysel_t ysel, ysel_m;
	dsp_dp_pkg::mac_req_t mreq;
	dsp_dp_pkg::sh_req_t sreq;
	dsp_dp_pkg::cond_t cond, cond_m;
	dsp_dp_pkg::status_t st;
	int bad_count = 0, check_count = 0, cycles = 0;
	dsp_seq_model dsp_seq_model_i (.divide_sign_step_i(divide_sign_step), .ysel_i(ysel),
		.cond_i(cond), .ysel_o(ysel_m), .cond_o(cond_m), .regs_o(regs));
	dsp_dp dsp_dp_i (.clk_i(clk_i), .rst_i(rst_i),
		.alu_x_input_0_i(regs[0]), .alu_x_input_1_i(regs[1]),
		.alu_y_input_0_i(regs[2]), .alu_y_input_1_i(regs[3]),
		.alu_feedback_i(regs[4]), .alu_result_i(regs[5]),
		.shifter_input_i(sin), .alu_xsel_i(xsel), .alu_ysel_i(ysel_m),
		.mac_req_i(mreq), .sh_req_i(sreq), .cond_i(cond_m),
		.status_i(st), .alu_x_o(ax), .alu_y_o(ay), .mac_result_o(mr),
		.mac_overflow_flag_o(mv), .shifter_result_o(sr),
		.shift_exponent_o(se), .block_exponent_register_o(sb),
		.cond_pass_o(pass));
	initial begin
		clk_i = 0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// a hung run still reaches the verdict
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 500) begin
			bad_count++;
			conclude();
		end
	end
	task automatic chk(input logic [39:0] s, input logic [39:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic mac(input dsp_dp_pkg::mac_op_t op, input logic [2:0] f,
		input logic [15:0] x, input logic [15:0] y, input logic ok);
		@(posedge clk_i);
		st <= 6'b100000;
		cond <= ok ? dsp_dp_pkg::C_TRUE : dsp_dp_pkg::C_NE;
		mreq <= {op, f, x, y};
		@(posedge clk_i);
		mreq.op <= dsp_dp_pkg::MAC_NONE;
		cond <= dsp_dp_pkg::C_TRUE;
		#1;
	endtask
	task automatic sh(input dsp_dp_pkg::sh_op_t op,
		input dsp_dp_pkg::sh_ref_t r, input logic o, input logic [7:0] n,
		input logic [15:0] x);
		@(posedge clk_i);
		sin <= x;
		sreq <= {op, r, o, 1'b1, n, dsp_dp_pkg::SH_SI};
		@(posedge clk_i);
		sreq.op <= dsp_dp_pkg::SOP_NONE;
		#1;
	endtask
	task automatic t_reset();
		@(posedge clk_i);
		#1 chk(mr, '0);
		chk(sr, '0);
		chk({se, sb}, 16'h00F0);
		chk(mv, 1'b0);
		$display("t_reset done");
	endtask
	task automatic t_cond();
		logic [15:0] e = 16'hDA56;
		st <= 6'b011000;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_i);
			cond <= dsp_dp_pkg::cond_t'(i);
			#1 chk(pass, e[i]);
		end
		$display("t_cond done");
	endtask
	task automatic t_mul();
		mac(dsp_dp_pkg::MAC_MUL, 3'b000, 16'hFFFF, 16'hFFFF, 1);
		chk(mr, 40'h00_FFFE_0001);
		mac(dsp_dp_pkg::MAC_MUL, 3'b110, 16'hFFFE, 16'h0003, 1);
		chk(mr, 40'hFF_FFFF_FFFA);
		mac(dsp_dp_pkg::MAC_MUL, 3'b001, 16'h0001, 16'h0001, 1);
		chk(mr, 40'h00_0000_8001);
		mac(dsp_dp_pkg::MAC_MUL, 3'b000, 16'h0002, 16'h0002, 0);
		chk(mr, 40'h00_0000_8001);
		mac(dsp_dp_pkg::MAC_MUL, 3'b110, 16'h7FFF, 16'h7FFF, 1);
		mac(dsp_dp_pkg::MAC_ACC, 3'b110, 16'h7FFF, 16'h7FFF, 1);
		mac(dsp_dp_pkg::MAC_ACC, 3'b110, 16'h7FFF, 16'h7FFF, 1);
		chk(mr, 40'h00_BFFD_0003);
		chk(mv, 1'b1);
		mac(dsp_dp_pkg::MAC_SAT, 3'b000, 16'h0000, 16'h0000, 1);
		chk(mr, 40'h7F_FFFF_FFFF);
		$display("t_mul done");
	endtask
	task automatic t_shift();
		sh(dsp_dp_pkg::SOP_LOGICAL_SHIFT, dsp_dp_pkg::REF_LO, 0, 8'h04, 16'h0001);
		chk(sr, 32'h0000_0010);
		sh(dsp_dp_pkg::SOP_LOGICAL_SHIFT, dsp_dp_pkg::REF_LO, 1, 8'h00, 16'h0001);
		chk(sr, 32'h0000_0011);
		sh(dsp_dp_pkg::SOP_LOGICAL_SHIFT, dsp_dp_pkg::REF_HI, 0, 8'hFF, 16'h8000);
		chk(sr, 32'h4000_0000);
		sh(dsp_dp_pkg::SOP_ARITHMETIC_SHIFT, dsp_dp_pkg::REF_HI, 0, 8'hFF, 16'h8000);
		chk(sr, 32'hC000_0000);
		$display("t_shift done");
	endtask
	task automatic t_ops();
		logic [15:0] xe [8] = '{16'h8001, 16'h1234, 16'h0F0F, 16'hFFFF,
			16'hFFFF, 16'h007F, 16'h0000, 16'hC000};
		logic [15:0] ye [3] = '{16'h5678, 16'h9ABC, 16'hDEF0};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			xsel <= dsp_dp_pkg::alu_xsel_t'(i);
			ysel <= dsp_dp_pkg::alu_ysel_t'(i % 3);
			#1 chk(ax, xe[i]);
			chk(ay, ye[i % 3]);
		end
		$display("t_ops done");
	endtask
	task automatic t_exp();
		sh(dsp_dp_pkg::SOP_EXP, dsp_dp_pkg::REF_HI, 0, 8'h00, 16'h0F0F);
		chk(se, 8'hFD);
		@(posedge clk_i);
		st <= 6'b000100;
		sh(dsp_dp_pkg::SOP_EXP, dsp_dp_pkg::REF_HIX, 0, 8'h00, 16'h0F0F);
		chk(se, 8'h01);
		sh(dsp_dp_pkg::SOP_BLOCK_SCALE_ADJUST, dsp_dp_pkg::REF_HI, 0, 8'h00, 16'h0F0F);
		chk(sb, 8'hFD);
		sh(dsp_dp_pkg::SOP_LEADING_BIT_ALIGN_SHIFT, dsp_dp_pkg::REF_HI, 0, 8'h03, 16'h0F0F);
		chk(sr, 32'h7878_0000);
		@(posedge clk_i);
		divide_sign_step <= 1'b1;
		ysel <= dsp_dp_pkg::ALU_Y0;
		#1 chk(ay, 16'h9ABC);
		$display("t_exp done");
	endtask
	initial begin
		rst_i = 1;
		divide_sign_step = 0;
		sin = '0;
		xsel = dsp_dp_pkg::ALU_X0;
		ysel = dsp_dp_pkg::ALU_Y0;
		mreq = '0;
		sreq = '0;
		cond = dsp_dp_pkg::C_TRUE;
		st = '0;
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		t_reset();
		t_cond();
		t_mul();
		t_shift();
		t_ops();
		t_exp();
		conclude();
	end
endmodule
